/* File: hdl/dual_slope_consts.vh */
// Constants for the dual-slope conversion sequencer
`ifndef DUAL_SLOPE_CONSTS_VH
`define DUAL_SLOPE_CONSTS_VH
`define CYCLE_LEN 14'd8192
`define INT_LEN 14'd2048
`define FULL_SCALE 13'd4096
`define NULL_MIN 14'd2048
`define NULL_LEN 14'd2048
`define START_DELAY 3'd7
`define RESULT_W 12
`define HS_BYTE_W 8
`endif

/* File: hdl/dual_slope_conversion_sequencer.v */
// Phase sequencer, result latch and output control of a dual-slope converter
//
// Behaviour
// - Mode low: direct, chip/byte enable controlled output
// - Mode pulse: one two-byte handshake, then direct
// - Mode held high: handshake after every conversion
// - Status rises when signal integrate begins
// - Status falls one clock after latch update
// - Latches never change while status low
// - Run high: continuous 8192-period cycles
// - Run low early: finish conversion, then null
// - Run low: minimum null, then wait
// - Integrate starts seven periods after run high
// - Run low after crossing: null immediately
// - Run low in null: halt at null end
// - 12-bit count latched with sign, over-range
// - Count 4096 is full scale
// - Phases in order null, integrate, reference
// - Integrate 2048 periods, then record sign
// - Count reference periods until comparator crossing
`timescale 1ns/1ps
`include "dual_slope_consts.vh"
module dual_slope_conversion_sequencer
(
	// Clock and reset
	input wire core_clk_in,
	input wire reset_in,
	// Converter control and analog feedback
	input wire run_in,
	input wire mode_in,
	input wire comparator_in,
	input wire send_in,
	// Direct mode enables, active low
	input wire chip_enable_n_in,
	input wire upper_byte_select_n_in,
	input wire lower_byte_select_n_in,
	// Handshake mode strobes, active low, and their active-high enable
	output wire load_n_out,
	output wire upper_byte_flag_n_out,
	output wire lower_byte_flag_n_out,
	output wire handshake_strobes_oe_out,
	// Phase indications
	output wire offset_null_phase_out,
	output wire integrate_phase_out,
	output wire reference_integrate_phase_out,
	output reg status_out,
	// Three-state result outputs
	output reg [`RESULT_W-1:0] data_out,
	output reg sign_flag_out,
	output reg over_range_out,
	output wire [7:0] data_oe_out,
	output wire flags_oe_out
);
	localparam PH_NULL = 2'd0;
	localparam PH_INT = 2'd1;
	localparam PH_REF = 2'd2;
	localparam PH_WAIT = 2'd3;
	localparam HS_IDLE = 3'd0;
	localparam HS_HI_WAIT = 3'd1;
	localparam HS_HI_LOAD = 3'd2;
	localparam HS_HI_HOLD = 3'd3;
	localparam HS_LO_WAIT = 3'd4;
	localparam HS_LO_LOAD = 3'd5;
	localparam HS_LO_HOLD = 3'd6;

	wire run_s;
	wire mode_s;
	wire cmp_s;
	reg [1:0] phase_r;
	reg [13:0] cnt_r;
	reg [12:0] ref_cnt_r;
	reg crossed_r;
	reg sign_r;
	reg hold_req_r;
	reg [2:0] delay_r;
	reg [2:0] hs_r;
	reg mode_d_r;
	reg hs_pending_r;
	reg status_fall_r;
	reg update_r;

	// Synchronise asynchronous inputs
	sync_bit u_sync_run (.core_clk_in(core_clk_in), .async_in(run_in),
		.sync_out(run_s));
	sync_bit u_sync_mode (.core_clk_in(core_clk_in), .async_in(mode_in),
		.sync_out(mode_s));
	sync_bit u_sync_cmp (.core_clk_in(core_clk_in),
		.async_in(comparator_in), .sync_out(cmp_s));

	assign offset_null_phase_out = (phase_r == PH_NULL) ||
		(phase_r == PH_WAIT);
	assign integrate_phase_out = (phase_r == PH_INT);
	assign reference_integrate_phase_out = (phase_r == PH_REF);

	// Phase sequencer: null, integrate, reference, fixed cycle
	always @(posedge core_clk_in)
	begin
		update_r <= 1'b0;
		if (reset_in)
		begin
			phase_r <= PH_NULL;
			cnt_r <= 14'd0;
			ref_cnt_r <= 13'd0;
			crossed_r <= 1'b0;
			sign_r <= 1'b0;
			hold_req_r <= 1'b0;
			delay_r <= 3'd0;
		end
		else
		begin
			case (phase_r)
			PH_NULL:
			begin
				cnt_r <= cnt_r + 14'd1;
				// Minimum null time, then halt while run is low
				if (cnt_r + 14'd1 >= (hold_req_r ? `NULL_MIN : `NULL_LEN))
				begin
					if (!run_s)
					begin
						phase_r <= PH_WAIT;
						delay_r <= 3'd0;
					end
					else if (!hold_req_r)
					begin
						phase_r <= PH_INT;
						cnt_r <= 14'd0;
					end
					else
					begin
						phase_r <= PH_WAIT;
						delay_r <= 3'd1;
					end
				end
			end
			PH_WAIT:
			begin
				// Seven periods from run high to integrate
				if (delay_r == 3'd0)
				begin
					if (run_s)
						delay_r <= 3'd1;
				end
				else if (delay_r == `START_DELAY - 3'd1)
				begin
					phase_r <= PH_INT;
					cnt_r <= 14'd0;
					hold_req_r <= 1'b0;
				end
				else
					delay_r <= delay_r + 3'd1;
			end
			PH_INT:
			begin
				cnt_r <= cnt_r + 14'd1;
				if (!run_s)
					hold_req_r <= 1'b1; // Finish, then null
				// Fixed integrate time, sign captured at its end
				if (cnt_r + 14'd1 == `INT_LEN)
				begin
					phase_r <= PH_REF;
					sign_r <= cmp_s;
					ref_cnt_r <= 13'd0;
					crossed_r <= 1'b0;
				end
			end
			PH_REF:
			begin
				cnt_r <= cnt_r + 14'd1;
				// Count until crossing, capped at full scale
				if (!crossed_r && ref_cnt_r != `FULL_SCALE)
				begin
					if (cmp_s != sign_r)
					begin
						crossed_r <= 1'b1;
						update_r <= 1'b1;
					end
					else
					begin
						ref_cnt_r <= ref_cnt_r + 13'd1;
						// Last period with no crossing latches over-range
						if (cnt_r + 14'd1 == `CYCLE_LEN - `NULL_LEN)
							update_r <= 1'b1;
					end
				end
				else if (!crossed_r)
				begin
					crossed_r <= 1'b1; // Over-range, fill remaining time
					update_r <= 1'b1;
				end
				if (!run_s && !crossed_r)
					hold_req_r <= 1'b1;
				// Early end after crossing when run low
				if (crossed_r && (!run_s || hold_req_r))
				begin
					phase_r <= PH_NULL;
					cnt_r <= 14'd0;
					hold_req_r <= 1'b1;
				end
				else if (cnt_r + 14'd1 == `CYCLE_LEN - `NULL_LEN)
				begin
					phase_r <= PH_NULL;
					cnt_r <= 14'd0;
				end
			end
			default:
				phase_r <= PH_NULL;
			endcase
		end
	end

	// Result latch, held during handshake and while status low
	always @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			data_out <= {`RESULT_W{1'b0}};
			sign_flag_out <= 1'b0;
			over_range_out <= 1'b0;
		end
		else if (update_r && status_out && hs_r == HS_IDLE)
		begin
			data_out <= ref_cnt_r[`RESULT_W-1:0];
			sign_flag_out <= sign_r;
			over_range_out <= ref_cnt_r[`RESULT_W];
		end
	end

	// Status rises at integrate start, falls a step after latch
	always @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			status_out <= 1'b0;
			status_fall_r <= 1'b0;
		end
		else
		begin
			status_fall_r <= update_r;
			if (phase_r == PH_INT && cnt_r == 14'd0)
				status_out <= 1'b1;
			else if (status_fall_r)
				status_out <= 1'b0;
		end
	end

	// Handshake output sequencer
	always @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			hs_r <= HS_IDLE;
			mode_d_r <= 1'b0;
			hs_pending_r <= 1'b0;
		end
		else
		begin
			mode_d_r <= mode_s;
			case (hs_r)
			HS_IDLE:
			begin
				if ((mode_s && !mode_d_r) || (mode_s && status_fall_r))
					hs_pending_r <= 1'b1;
				// Entry waits until latch data is stable
				if (hs_pending_r && !update_r && !status_fall_r)
				begin
					hs_pending_r <= 1'b0;
					hs_r <= HS_HI_WAIT;
				end
			end
			HS_HI_WAIT: if (send_in) hs_r <= HS_HI_LOAD;
			HS_HI_LOAD: hs_r <= HS_HI_HOLD;
			HS_HI_HOLD: if (send_in) hs_r <= HS_LO_WAIT;
			HS_LO_WAIT: if (send_in) hs_r <= HS_LO_LOAD;
			HS_LO_LOAD: hs_r <= HS_LO_HOLD;
			HS_LO_HOLD: if (send_in) hs_r <= HS_IDLE;
			default: hs_r <= HS_IDLE;
			endcase
		end
	end

	// Output enables: direct by enables, handshake by sequencer
	wire hs_on = (hs_r != HS_IDLE);
	wire hi_act = (hs_r == HS_HI_LOAD) || (hs_r == HS_HI_HOLD);
	wire lo_act = (hs_r == HS_LO_LOAD) || (hs_r == HS_LO_HOLD);
	wire dir_hi = !mode_s && !hs_on && !chip_enable_n_in &&
		!upper_byte_select_n_in;
	wire dir_lo = !mode_s && !hs_on && !chip_enable_n_in &&
		!lower_byte_select_n_in;
	assign data_oe_out = {8{hs_on ? lo_act : dir_lo}};
	assign flags_oe_out = hs_on ? hi_act : dir_hi;
	assign handshake_strobes_oe_out = hs_on || mode_s;
	assign load_n_out = !((hs_r == HS_HI_LOAD) || (hs_r == HS_LO_LOAD));
	assign upper_byte_flag_n_out = !hi_act;
	assign lower_byte_flag_n_out = !lo_act;
endmodule // dual_slope_conversion_sequencer

/* File: hdl/sync_bit.v */
// Two-stage synchroniser for one asynchronous input
`timescale 1ns/1ps
module sync_bit
(
	// Clock
	input wire core_clk_in,
	// Raw and synchronised level
	input wire async_in,
	output reg sync_out
);
	reg meta_r;

	// First stage feeds only the second stage
	always @(posedge core_clk_in)
	begin
		meta_r <= async_in;
		sync_out <= meta_r;
	end
endmodule // sync_bit

/* File: tb/seq_checker.sv */
// Port assertions for the dual-slope conversion sequencer
`timescale 1ns/1ps
module seq_checker
(
	// Clock and reset
	input wire core_clk_in,
	input wire reset_in,
	// Observed ports
	input wire chip_enable_n_in,
	input wire lower_byte_select_n_in,
	input wire load_n_out,
	input wire upper_byte_flag_n_out,
	input wire lower_byte_flag_n_out,
	input wire handshake_strobes_oe_out,
	input wire offset_null_phase_out,
	input wire integrate_phase_out,
	input wire reference_integrate_phase_out,
	input wire status_out,
	input wire [11:0] data_out,
	input wire over_range_out,
	input wire [7:0] data_oe_out
);
	reg [11:0] int_cnt_r;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	// Counts integrate periods
	always @(posedge core_clk_in)
		if (reset_in || !integrate_phase_out)
			int_cnt_r <= 12'h000;
		else
			int_cnt_r <= int_cnt_r + 12'h001;
	chk_data_hold: assert property
		(!status_out && $past(!status_out) |-> $stable(data_out))
		else $error("data changed while status low");
	chk_status_rise: assert property
		($rose(status_out) |-> integrate_phase_out)
		else $error("status rose outside integrate");
	chk_phase_one: assert property
		($onehot({offset_null_phase_out, integrate_phase_out,
			reference_integrate_phase_out}))
		else $error("phase outputs not one-hot");
	chk_int_entry: assert property
		($rose(integrate_phase_out) |-> $past(offset_null_phase_out))
		else $error("integrate not entered from null");
	chk_int_len: assert property
		($fell(integrate_phase_out) |-> int_cnt_r == 12'h800
			&& reference_integrate_phase_out)
		else $error("integrate length wrong");
	chk_load_pulse: assert property
		(!load_n_out |=> load_n_out)
		else $error("load strobe longer than one cycle");
	chk_load_flag: assert property
		(!load_n_out |-> handshake_strobes_oe_out
			&& (upper_byte_flag_n_out != lower_byte_flag_n_out))
		else $error("load without one byte flag");
	chk_direct_oe: assert property
		(!handshake_strobes_oe_out && $stable(chip_enable_n_in)
			&& $stable(lower_byte_select_n_in) |-> data_oe_out
			== {8{!chip_enable_n_in && !lower_byte_select_n_in}})
		else $error("direct low byte enable wrong");
	chk_over_zero: assert property
		(over_range_out |-> data_out == 12'h000)
		else $error("over-range with nonzero data");
endmodule // seq_checker
bind dual_slope_conversion_sequencer seq_checker u_seq_checker
	(.core_clk_in, .reset_in, .chip_enable_n_in, .lower_byte_select_n_in,
	.load_n_out, .upper_byte_flag_n_out, .lower_byte_flag_n_out,
	.handshake_strobes_oe_out, .offset_null_phase_out,
	.integrate_phase_out, .reference_integrate_phase_out, .status_out,
	.data_out, .over_range_out, .data_oe_out);

/* File: tb/tb_dual_slope_conversion_sequencer.sv */
// Self-checking bench for the dual-slope conversion sequencer
`timescale 1ns/1ps
module tb_dual_slope_conversion_sequencer;
	reg core_clk_in = 1'b0;
	reg reset_in = 1'b1;
	reg run_in = 1'b1;
	reg mode_in = 1'b0;
	reg comp = 1'b0;
	reg ce_n = 1'b1;
	reg ubs_n = 1'b1;
	reg lbs_n = 1'b1;
	wire send, load_n, ufl_n, lfl_n, hs_oe, az, intg, ref_ph, status;
	wire sign, over, flags_oe;
	wire [11:0] data;
	wire [7:0] data_oe;
	wire [3:0] hi_n, lo_n;
	integer n_errors = 0;
	integer check_count = 0;
	integer cyc = 0;
	integer t, last, period;
	reg [11:0] r1, r2;
	always #10 core_clk_in = ~core_clk_in;
	dual_slope_conversion_sequencer u_dual_slope_conversion_sequencer
		(.core_clk_in(core_clk_in), .reset_in(reset_in), .run_in(run_in),
		.mode_in(mode_in), .comparator_in(comp), .send_in(send),
		.chip_enable_n_in(ce_n), .upper_byte_select_n_in(ubs_n),
		.lower_byte_select_n_in(lbs_n), .load_n_out(load_n),
		.upper_byte_flag_n_out(ufl_n), .lower_byte_flag_n_out(lfl_n),
		.handshake_strobes_oe_out(hs_oe), .offset_null_phase_out(az),
		.integrate_phase_out(intg), .reference_integrate_phase_out(ref_ph),
		.status_out(status), .data_out(data), .sign_flag_out(sign),
		.over_range_out(over), .data_oe_out(data_oe),
		.flags_oe_out(flags_oe));
	uart_rx_model u_uart_rx_model (.core_clk_in(core_clk_in),
		.load_n_in(load_n), .upper_flag_n_in(ufl_n), .send_out(send),
		.hi_out(hi_n), .lo_out(lo_n));
	// Cycle count, hang limit and status period
	always @(posedge core_clk_in)
	begin
		cyc = cyc + 1;
		if (cyc == 90000)
		begin
			n_errors = n_errors + 1;
			stop_test;
		end
	end
	always @(posedge status)
	begin
		period = cyc - last;
		last = cyc;
	end
	task check(input [8*8:1] nm, input [31:0] exp, input [31:0] got);
	begin
		check_count = check_count + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("unexpected %0s exp %0h got %0h", nm, exp, got);
		end
	end
	endtask
	// Crossing n periods into reference, result taken at status fall
	task convert(input integer n, output [11:0] res);
	begin
		@(posedge ref_ph);
		repeat (n) @(posedge core_clk_in);
		comp <= 1'b1;
		@(negedge status);
		res = data;
		comp <= 1'b0;
	end
	endtask
	task dir(input [2:0] en, input [7:0] e_oe, input e_fl);
	begin
		{ce_n, ubs_n, lbs_n} <= en;
		repeat (3) @(posedge core_clk_in);
		check("data_oe", e_oe, data_oe);
		check("flag_oe", e_fl, flags_oe);
	end
	endtask
	task stop_test;
	begin
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	// Main sequence
	initial
	begin
		repeat (8) @(posedge core_clk_in);
		reset_in <= 1'b0;
		convert(100, r1);
		check("count", 1, r1 >= 100 && r1 <= 104);
		check("sign", 0, sign);
		convert(1000, r2);
		check("delta", 900, r2 - r1);
		check("period", 8192, period);
		@(posedge ref_ph);
		@(negedge status);
		check("over", 1, over);
		dir(3'b010, 8'hff, 1'b0);
		dir(3'b001, 8'h00, 1'b1);
		dir(3'b100, 8'h00, 1'b0);
		@(posedge intg);
		run_in <= 1'b0;
		convert(50, r1);
		check("held", 1, r1 >= 50 && r1 <= 54);
		repeat (3000) @(posedge core_clk_in);
		check("wait", 2, {az, status});
		run_in <= 1'b1;
		t = cyc;
		@(posedge status);
		check("start", 1, cyc - t >= 8 && cyc - t <= 11);
		convert(20, r1);
		run_in <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		check("short", 1, az);
		// Null time is measured from the early end of reference
		t = cyc;
		repeat (10) @(posedge core_clk_in);
		run_in <= 1'b1;
		@(posedge status);
		check("min_null", 1, cyc - t >= 2048);
		mode_in <= 1'b1;
		wait (hi_n == 4'h1);
		check("order", 0, lo_n);
		wait (lo_n == 4'h1);
		// Mode still high: the next conversion sends on its own
		@(negedge status);
		repeat (40) @(posedge core_clk_in);
		check("auto", 8'h22, {hi_n, lo_n});
		mode_in <= 1'b0;
		repeat (40) @(posedge core_clk_in);
		mode_in <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		mode_in <= 1'b0;
		t = cyc;
		wait (lo_n == 4'h3);
		check("pulse", 1, cyc - t < 200);
		repeat (10) @(posedge core_clk_in);
		check("direct", 0, hs_oe);
		stop_test;
	end
endmodule // tb_dual_slope_conversion_sequencer

/* File: tb/uart_rx_model.sv */
// Receiver model that paces handshake output with its ready line
`timescale 1ns/1ps
module uart_rx_model
#(parameter STALL = 5)
(
	// Clock
	input wire core_clk_in,
	// Strobes from the converter
	input wire load_n_in,
	input wire upper_flag_n_in,
	// Ready and byte counts
	output reg send_out,
	output reg [3:0] hi_out,
	output reg [3:0] lo_out
);
	integer wait_r = 0;
	initial send_out = 1'b1;
	initial hi_out = 4'h0;
	initial lo_out = 4'h0;
	// Busy for STALL+1 cycles after each load, counting bytes by flag
	always @(posedge core_clk_in)
	begin
		if (!load_n_in)
		begin
			send_out <= 1'b0;
			wait_r <= STALL;
			if (!upper_flag_n_in)
				hi_out <= hi_out + 4'h1;
			else
				lo_out <= lo_out + 4'h1;
		end
		else if (wait_r > 0)
			wait_r <= wait_r - 1;
		else
			send_out <= 1'b1;
	end
endmodule // uart_rx_model
